//--- core/acs_defines.svh
// Offsets, field positions, reset values and counts for the channel sequencer.
// Assumes inclusion by bare name from the top module and the test bench.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ****************************************
// APB register offsets
// ****************************************
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_MASK 12'h004
`define ACS_OFF_STATUS 12'h008
`define ACS_OFF_CONFIG 12'h00C
`define ACS_OFF_RESULT 12'h010

// ****************************************
// Field positions
// ****************************************
`define ACS_CFG_ENABLE_BIT 0
`define ACS_ST_MODE_LSB 0
`define ACS_ST_CHAN_LSB 4
`define ACS_ST_POS_LSB 8
`define ACS_ST_BUSY_BIT 12

// ****************************************
// Reset values and encodings
// ****************************************
`define ACS_CTRL_RESET 12'h000
`define ACS_MASK_RESET 16'h0000
`define ACS_CONFIG_RESET 1'b1
`define ACS_CODING_STRAIGHT 1'b1
`define ACS_RANGE_SINGLE 1'b1

// ****************************************
// Transfer counts and result codes
// ****************************************
`define ACS_CTRL_BITS 12
`define ACS_WORD_BITS 16
`define ACS_FULL_SCALE 12'hFFF
`define ACS_MID_SCALE 12'h800

`endif

//--- core/acs_pkg.sv
// Types shared by the channel sequencer.
// Assumes acs_defines.svh is on the include path.
package acs_pkg;

    // ****************************************
    // Sequencer modes
    // ****************************************
    typedef enum logic [1:0] {
        ACS_FIXED = 2'b00,
        ACS_MASK_PEND = 2'b01,
        ACS_MASK_RUN = 2'b10,
        ACS_CONSEC = 2'b11
    } acs_mode_t;

    // ****************************************
    // Control word, first serial bit at the top
    // ****************************************
    typedef struct packed {
        logic write_en;
        logic sequence_enable_bit;
        logic spare;
        logic chan_addr_bit2;
        logic chan_addr_bit1;
        logic chan_addr_bit0;
        logic [1:0] power_mode;
        logic mask_load_bit;
        logic weak_drive;
        logic range_sel;
        logic coding_sel;
    } acs_ctrl_t;

endpackage

//--- core/acs_top.sv
// Channel selection, sequencing and result formatting of an eight input converter.
// Assumes cs_n, sclk and din come from an outside host; APB and sample_level on pclk.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "acs_defines.svh"

// Behaviour
// - Coding bit of control selects straight binary or twos complement results.
// - Range bit 1 spans zero to reference; 0 spans zero to twice reference.
// - Twos complement on doubled range puts reference input at zero code.
// - Result word: leading zero, three channel bits, then twelve result bits.
// - Ten bit result plus two zeros, or eight bit plus four zeros.
// - Three channel address bits of control pick one of eight channels.
// - After mask load, convert lowest selected channel, then next higher each transfer.
// - Sequence runs until a control write sets sequence bits other than 1,0.
// - After last selected channel, wrap to first masked channel and repeat.
// - Sequence bits 1,1 run channels zero up to the addressed channel.
// - Consecutive mode counts 0 upward to final channel, then restarts at 0.
// - With write bit set, first twelve serial bits load the control register.
// - Sixteen bit mask, first bit channel 0; first eight-channel sequence, then second.
// - Mask loads over sixteen falling edges after a 0,1 control write.
module acs_top
    import acs_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic [2:0] sample_chan,
    input wire logic [12:0] sample_level
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [3:0] first_set(input logic [15:0] mask, input logic [3:0] start);
        logic [3:0] pos;
        logic found;
        pos = start;
        found = 1'b0;
        first_set = start;
        for (int k = 0; k < 16; k++) begin
            if (!found && mask[4'd15 - pos]) begin
                first_set = pos;
                found = 1'b1;
            end
            pos = pos + 4'd1;
        end
    endfunction

    function automatic logic [15:0] format_word(input logic [2:0] chan,
                                                input logic [12:0] level,
                                                input logic range_sel,
                                                input logic coding_sel);
        logic [11:0] code;
        if (range_sel == `ACS_RANGE_SINGLE) begin
            code = level[12] ? `ACS_FULL_SCALE : level[11:0];
        end else begin
            code = level[12:1];
        end
        if (coding_sel != `ACS_CODING_STRAIGHT) begin
            code = code ^ `ACS_MID_SCALE;
        end
        for (int b = 0; b < 12 - RES_BITS; b++) begin
            code[b] = 1'b0;
        end
        format_word = {1'b0, chan, code};
    endfunction

    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [1:0] din_sync;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync <= 3'h7;
            sclk_sync <= 3'h7;
            din_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], cs_n};
            sclk_sync <= {sclk_sync[1:0], sclk};
            din_sync <= {din_sync[0], din};
        end
    end

    assign cs_fall = cs_sync[2] && !cs_sync[1];
    assign cs_rise = !cs_sync[2] && cs_sync[1];
    assign sclk_fall = sclk_sync[2] && !sclk_sync[1];

    // ****************************************
    // State
    // ****************************************
    acs_ctrl_t ctrl;
    acs_mode_t mode;
    logic [15:0] mask;
    logic [15:0] mask_sr;
    logic [11:0] din_sr;
    logic [15:0] out_sr;
    logic [15:0] last_word;
    logic [4:0] fall_cnt;
    logic [3:0] pos;
    logic xfer;
    logic wrote;
    logic enable;
    logic [2:0] addr;
    logic [3:0] first_pos;
    logic [3:0] next_pos;
    logic [15:0] next_mask;

    assign addr = {ctrl.chan_addr_bit2, ctrl.chan_addr_bit1, ctrl.chan_addr_bit0};
    assign next_mask = {mask_sr[14:0], din_sync[1]};
    assign first_pos = first_set(mask_sr, 4'd0);
    assign next_pos = first_set(mask, pos + 4'd1);

    // ****************************************
    // Transfer framing and bit counting
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer <= 1'b0;
            fall_cnt <= 5'h00;
        end else if (cs_fall && enable) begin
            xfer <= 1'b1;
            fall_cnt <= 5'h00;
        end else if (cs_rise) begin
            xfer <= 1'b0;
        end else if (xfer && sclk_fall && fall_cnt != 5'(`ACS_WORD_BITS)) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    // ****************************************
    // Serial input: control and mask
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_sr <= 12'h000;
            mask_sr <= `ACS_MASK_RESET;
            ctrl <= acs_ctrl_t'(`ACS_CTRL_RESET);
            wrote <= 1'b0;
        end else if (cs_fall && enable) begin
            wrote <= 1'b0;
        end else if (xfer && sclk_fall && fall_cnt != 5'(`ACS_WORD_BITS)) begin
            if (mode == ACS_MASK_PEND) begin
                mask_sr <= next_mask;
            end else if (fall_cnt < 5'(`ACS_CTRL_BITS)) begin
                din_sr <= {din_sr[10:0], din_sync[1]};
                if (fall_cnt == 5'(`ACS_CTRL_BITS - 1) && din_sr[10]) begin
                    ctrl <= acs_ctrl_t'({din_sr[10:0], din_sync[1]});
                    wrote <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Sequencer and channel selection
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= ACS_FIXED;
            mask <= `ACS_MASK_RESET;
            pos <= 4'h0;
            sample_chan <= 3'h0;
        end else if (cs_fall && enable) begin
            case (mode)
                ACS_MASK_RUN: begin
                    pos <= next_pos;
                    sample_chan <= next_pos[2:0];
                end
                ACS_CONSEC: begin
                    sample_chan <= (sample_chan == addr) ? 3'h0 : sample_chan + 3'h1;
                end
                default: begin
                end
            endcase
        end else if (cs_rise && xfer) begin
            if (mode == ACS_MASK_PEND) begin
                if (fall_cnt == 5'(`ACS_WORD_BITS) && mask_sr != 16'h0000) begin
                    mask <= mask_sr;
                    pos <= first_pos;
                    sample_chan <= first_pos[2:0];
                    mode <= ACS_MASK_RUN;
                end else begin
                    mode <= ACS_FIXED;
                    sample_chan <= addr;
                end
            end else if (wrote) begin
                case ({ctrl.sequence_enable_bit, ctrl.mask_load_bit})
                    2'b00: begin
                        mode <= ACS_FIXED;
                        sample_chan <= addr;
                    end
                    2'b01: begin
                        mode <= ACS_MASK_PEND;
                        sample_chan <= addr;
                    end
                    2'b11: begin
                        mode <= ACS_CONSEC;
                        sample_chan <= 3'h0;
                    end
                    default: begin
                        if (mode == ACS_FIXED) begin
                            sample_chan <= addr;
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Serial output
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_sr <= 16'h0000;
            last_word <= 16'h0000;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else if (cs_fall && enable) begin
            out_sr <= format_word(sample_chan, sample_level, ctrl.range_sel,
                                  ctrl.coding_sel);
            last_word <= format_word(sample_chan, sample_level, ctrl.range_sel,
                                     ctrl.coding_sel);
            dout <= 1'b0;
            dout_oe <= 1'b1;
        end else if (cs_rise) begin
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else if (xfer && sclk_fall) begin
            out_sr <= {out_sr[14:0], 1'b0};
            dout <= out_sr[14];
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign access = psel && penable && pready;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `ACS_OFF_CTRL: rd_mux = {20'h00000, ctrl};
            `ACS_OFF_MASK: rd_mux = {16'h0000, mask};
            `ACS_OFF_STATUS: begin
                rd_mux[`ACS_ST_MODE_LSB +: 2] = mode;
                rd_mux[`ACS_ST_CHAN_LSB +: 3] = sample_chan;
                rd_mux[`ACS_ST_POS_LSB +: 4] = pos;
                rd_mux[`ACS_ST_BUSY_BIT] = xfer;
            end
            `ACS_OFF_CONFIG: rd_mux[`ACS_CFG_ENABLE_BIT] = enable;
            `ACS_OFF_RESULT: rd_mux = {16'h0000, last_word};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= `ACS_CONFIG_RESET;
        end else if (access && pwrite && paddr == `ACS_OFF_CONFIG) begin
            enable <= pwdata[`ACS_CFG_ENABLE_BIT];
        end
    end

endmodule // acs_top

//--- tb/acs_assertions.sv
// Port-level checks of the channel sequencer.
// Assumes it is bound into acs_top and sees only that module's ports.
`timescale 1ns/1ps
module acs_assertions
    import acs_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic [2:0] sample_chan,
    input wire logic [12:0] sample_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Bus answer
    // ****************************************
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("pready without setup");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer with data");
    // ****************************************
    // Serial framing
    // ****************************************
    a_lead_zero: assert property ($rose(dout_oe) |-> !dout)
        else $error("first bit not zero");
    a_oe_after_cs: assert property ($rose(dout_oe) |-> !cs_n && !$past(cs_n, 2))
        else $error("output enabled without select");
    a_oe_quiet: assert property (cs_n && !dout_oe |=> !dout_oe)
        else $error("output enabled while deselected");
    a_oe_drop: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
        else $error("output enable stuck after deselect");
    a_chan_stable: assert property (dout_oe && $past(dout_oe, 3) |-> $stable(sample_chan))
        else $error("channel moved inside a transfer");
    a_dout_on_fall: assert property ($changed(dout) && dout_oe && $past(dout_oe)
        |-> !$past(sclk, 2)) else $error("data moved without clock fall");
    c_frame: cover property ($rose(dout_oe));
    c_error: cover property (pslverr);
    c_chan_move: cover property ($changed(sample_chan));
endmodule // acs_assertions

bind acs_top acs_assertions #(.RES_BITS(RES_BITS)) acs_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .sample_chan(sample_chan), .sample_level(sample_level));

//--- tb/acs_host.sv
// Serial host model framing one sixteen bit transfer per call.
// Assumes the block samples cs_n, sclk and din on its own clock.
`timescale 1ns/1ps
module acs_host
    import acs_pkg::*;
(
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    task automatic xfer(input logic [15:0] w, output logic [15:0] rx, output logic oe);
        #0.3;
        cs_n = 1'b0;
        din = w[15];
        #32;
        oe = dout_oe;
        rx[15] = dout;
        for (int k = 1; k <= 16; k++) begin
            sclk = 1'b0;
            #32;
            sclk = 1'b1;
            if (k < 16) begin
                din = w[15 - k];
                rx[15 - k] = dout;
            end
            #32;
        end
        cs_n = 1'b1;
        din = ~din;
        #40;
    endtask
endmodule // acs_host

//--- tb/test_acs_top.sv
// Self-checking bench of the channel sequencer.
// Assumes acs_pkg and acs_defines.svh are compiled and on the include path.
`timescale 1ns/1ps
`include "acs_defines.svh"
`define TB_CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_acs_top
    import acs_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, pr, ps, oe;
    logic cs_n, sclk, din, dout, dout_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] sample_chan;
    logic [12:0] sample_level;
    logic [15:0] rx;
    int err_count, tests_run;
    logic [12:0] lvl_tab [8] = '{13'h0123, 13'h1FFF, 13'h0800, 13'h1000, 13'h0ABC,
        13'h0FFF, 13'h0456, 13'h1234};
    acs_top acs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .sample_chan(sample_chan), .sample_level(sample_level));
    acs_host acs_host_inst (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe));
    // ****************************************
    // Expected values and bus cycles
    // ****************************************
    function automatic logic [15:0] exp_word(input logic [2:0] c, input logic r, s);
        logic [11:0] code;
        code = r ? ((lvl_tab[c] > 13'h0FFF) ? 12'hFFF : lvl_tab[c][11:0]) : lvl_tab[c][12:1];
        if (!s) begin
            code = code ^ 12'h800;
        end
        return {1'h0, c, code};
    endfunction
    function automatic logic [15:0] cw(input logic [1:0] ws, input logic [2:0] c, mrs);
        return {ws, 1'h0, c, 2'h3, mrs[2], 1'h0, mrs[1:0], 4'h0};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0);
        `TB_CHECK({er, rd}, e)
    endtask
    task automatic step(input logic [15:0] w, input logic [2:0] c);
        @(posedge pclk);
        acs_host_inst.xfer(w, rx, oe);
        `TB_CHECK(oe, 1'b1)
        `TB_CHECK(rx, exp_word(c, pr, ps))
        if (w[15]) begin
            pr = w[5];
            ps = w[4];
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs_reset;
        rd_chk(`ACS_OFF_CONFIG, 33'h1);
        rd_chk(`ACS_OFF_CTRL, 33'h0);
        rd_chk(`ACS_OFF_STATUS, 33'h0);
    endtask
    task automatic t_fixed;
        for (int c = 0; c < 8; c++) begin
            step(cw(2'h2, 3'(c), 3'h3), (c == 0) ? 3'h0 : 3'(c - 1));
        end
        rd_chk(`ACS_OFF_CTRL, 33'h9F3);
    endtask
    task automatic t_coding;
        for (int i = 0; i < 4; i++) begin
            step(cw(2'h2, 3'h3, {1'h0, 2'(i)}), (i == 0) ? 3'h7 : 3'h3);
        end
        step(cw(2'h2, 3'h1, 3'h3), 3'h3);
        step(16'h0000, 3'h1);
    endtask
    task automatic t_mask;
        step(cw(2'h2, 3'h1, 3'h7), 3'h1);
        step(16'h5022, 3'h1);
        step(16'h0000, 3'h1);
        step(16'h0000, 3'h3);
        step(cw(2'h3, 3'h7, 3'h3), 3'h2);
        step(16'h0000, 3'h6);
        step(16'h0000, 3'h1);
        rd_chk(`ACS_OFF_MASK, 33'h5022);
        rd_chk(`ACS_OFF_STATUS, 33'h332);
        step(cw(2'h2, 3'h5, 3'h3), 3'h3);
        step(16'h0000, 3'h5);
    endtask
    task automatic t_consec;
        step(cw(2'h3, 3'h2, 3'h7), 3'h5);
        step(16'h0000, 3'h0);
        step(16'h0000, 3'h1);
        step(16'h0000, 3'h2);
        step(16'h0000, 3'h0);
        step(cw(2'h2, 3'h4, 3'h3), 3'h1);
        step(16'h0000, 3'h4);
    endtask
    task automatic t_enable;
        apb(1'b1, `ACS_OFF_CONFIG, 32'h0);
        acs_host_inst.xfer(16'h0000, rx, oe);
        `TB_CHECK(oe, 1'b0)
        apb(1'b1, `ACS_OFF_CONFIG, 32'h1);
        apb(1'b1, `ACS_OFF_CTRL, 32'hFFF);
        rd_chk(`ACS_OFF_CTRL, 33'h933);
        step(16'h0000, 3'h4);
        step(cw(2'h3, 3'h6, 3'h3), 3'h4);
        step(16'h0000, 3'h6);
        rd_chk(`ACS_OFF_RESULT, {17'h0, exp_word(3'h6, pr, ps)});
        rd_chk(12'h014, 33'h100000000);
    endtask
    task automatic results;
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        sample_level <= lvl_tab[sample_chan];
    end
    initial begin
        #200000;
        err_count++;
        results;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sample_level = 13'h0000;
        pr = 1'b0;
        ps = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs_reset;
        t_fixed;
        t_coding;
        t_mask;
        t_consec;
        t_enable;
        results;
    end
endmodule // test_acs_top
